// ### inc/alsc_pkg.sv
// Package for the alarm and level steering comparator
package alsc_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFF_ALARM_LO_TRIG  = 8'h00;
   localparam logic [7:0] OFF_ALARM_LO_OUT   = 8'h04;
   localparam logic [7:0] OFF_ALARM_HI_TRIG  = 8'h08;
   localparam logic [7:0] OFF_ALARM_HI_OUT   = 8'h0c;
   localparam logic [7:0] OFF_ALARM_CTRL     = 8'h10;
   localparam logic [7:0] OFF_STEER_CTRL     = 8'h14;
   localparam logic [7:0] OFF_STEER_LVL0     = 8'h18;
   localparam logic [7:0] OFF_STEER_LVL1     = 8'h1c;
   localparam logic [7:0] OFF_STEER_LVL2     = 8'h20;
   localparam logic [7:0] OFF_MODE           = 8'h24;
   localparam logic [7:0] OFF_FALLBACK       = 8'h28;
   localparam logic [7:0] OFF_STATUS         = 8'h2c;
   localparam logic [7:0] OFF_IRQ_STAT       = 8'h30;
   localparam logic [7:0] OFF_IRQ_MASK       = 8'h34;

   // Mode byte fields
   localparam int MODE_CKSUM_BIT = 7;
   localparam int MODE_DIG_BIT   = 6;
   localparam int MODE_ALARM_BIT = 5;
   localparam int MODE_STEER_BIT = 4;
   localparam int MODE_VMO_BIT   = 2;
   localparam int MODE_CMO_BIT   = 0;

   // Selector field in the control byte
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 4;

   // Selector codes
   localparam logic [3:0] SEL_GAIN_STAGE = 4'h0;
   localparam logic [3:0] SEL_TEMP_AMP   = 4'h2;
   localparam logic [3:0] SEL_VOLT_MODE  = 4'h3;
   localparam logic [3:0] SEL_GP_PIN_A   = 4'h4;
   localparam logic [3:0] SEL_GP_PIN_B   = 4'h5;
   localparam logic [3:0] SEL_INSTR_AMP  = 4'h6;

   // Interrupt status bits
   localparam int IRQ_LO_BIT    = 0;
   localparam int IRQ_HI_BIT    = 1;
   localparam int IRQ_STEER_BIT = 2;
   localparam int IRQ_CKSUM_BIT = 3;
   localparam int IRQ_W         = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Digitized inputs, one 10-bit word each
   typedef struct packed
   {
      logic [9:0] temperature_amp_out;
      logic [9:0] instr_amp_out;
      logic [9:0] gain_stage_out;
      logic [9:0] voltage_mode_out;
      logic [9:0] gp_pin_a;
      logic [9:0] gp_pin_b;
   } alsc_samples_s;

   typedef enum logic [2:0]
   {
      ST_NORMAL = 3'b001,
      ST_ALARM  = 3'b010,
      ST_STEER  = 3'b100
   } alsc_mode_e;

endpackage

// ### rtl/alsc_top.sv
// Alarm and level steering comparator with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - A limit crossing replaces the conditioned output by the programmed limit output.
// - Alarm setup is low trigger, low output, high trigger, high output, control byte.
// - Thresholds and outputs are 8-bit and match the top eight bits of a 10-bit sample.
// - The selector code sits in the top four bits of the alarm control byte.
// - Codes: temperature 0010, instrument amp 0110, gain 0000, voltage 0011, pins 0100/0101.
// - Steering compares the top eight sample bits to three levels and drives both pins.
// - Alarm and steering share one selector and comparator and never run together.
// - Steering setup is one control byte and three transition levels.
// - The steering control byte uses the alarm control layout with selector on top.
// - With checksum test on and a failed checksum the output takes the fallback value.
// - Below low trigger emit the low value in digital mode; above high emit the high value.
// - Steering mode disables the alarm regardless of the alarm enable.
// - With steering on the pins are a two-bit output, otherwise analog inputs.
module alsc_top
(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output      logic                   s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output      logic                   s_axi_wready,
   output      logic [1:0]             s_axi_bresp,
   output      logic                   s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output      logic                   s_axi_arready,
   output      logic [31:0]            s_axi_rdata,
   output      logic [1:0]             s_axi_rresp,
   output      logic                   s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Analog chain samples
   input  wire alsc_pkg::alsc_samples_s samples,
   input  wire logic                   sample_valid,
   input  wire logic [9:0]             conditioned_out,
   input  wire logic                   cksum_fail,
   // Output stage
   output      logic [9:0]             drive_out,
   output      logic                   digital_output_mode,
   output      logic [1:0]             gp_pins_out,
   output      logic [1:0]             gp_pins_oe_n,
   output      logic                   irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   logic [7:0]               lo_trig_r, lo_out_r, hi_trig_r, hi_out_r, alarm_ctrl_r;
   logic [7:0]               steer_ctrl_r, mode_r;
   logic [7:0]               lvl_r [3];
   logic [9:0]               fallback_r;
   logic [alsc_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r;

   // AXI handshake state
   logic                     aw_got_r, w_got_r;
   logic [7:0]               awaddr_r;
   logic [31:0]              wdata_r;
   logic [3:0]               wstrb_r;

   // Write happens once both address and data are held and no response pends
   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire wr_fire  = aw_got_r & w_got_r & ~s_axi_bvalid;
   wire wr_byte0 = wr_fire & wstrb_r[0];
   wire wr_byte1 = wr_fire & wstrb_r[1];
   wire wr_hit   = (awaddr_r <= alsc_pkg::OFF_IRQ_MASK) && (awaddr_r[1:0] == 2'h0);
   wire rd_take  = s_axi_arvalid & s_axi_arready;

   // Address ready only while idle; accepting both in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_got_r <= 1'b0;
         if (w_take)
         begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_got_r <= 1'b0;
         s_axi_awready <= ~aw_got_r & ~aw_take & ~s_axi_awready;
         s_axi_wready  <= ~w_got_r & ~w_take & ~s_axi_wready;
      end
   end

   // Write response, raised on the same edge that stores the write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= alsc_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? alsc_pkg::RESP_OKAY : alsc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Register decode; only the low byte (two for the fallback) is stored
   wire wsel_lo_t  = wr_byte0 && awaddr_r == alsc_pkg::OFF_ALARM_LO_TRIG;
   wire wsel_lo_o  = wr_byte0 && awaddr_r == alsc_pkg::OFF_ALARM_LO_OUT;
   wire wsel_hi_t  = wr_byte0 && awaddr_r == alsc_pkg::OFF_ALARM_HI_TRIG;
   wire wsel_hi_o  = wr_byte0 && awaddr_r == alsc_pkg::OFF_ALARM_HI_OUT;
   wire wsel_actl  = wr_byte0 && awaddr_r == alsc_pkg::OFF_ALARM_CTRL;
   wire wsel_sctl  = wr_byte0 && awaddr_r == alsc_pkg::OFF_STEER_CTRL;
   wire wsel_mode  = wr_byte0 && awaddr_r == alsc_pkg::OFF_MODE;
   wire wsel_fb    = wr_fire && awaddr_r == alsc_pkg::OFF_FALLBACK;
   wire wsel_istat = wr_byte0 && awaddr_r == alsc_pkg::OFF_IRQ_STAT;
   wire wsel_imask = wr_byte0 && awaddr_r == alsc_pkg::OFF_IRQ_MASK;

   // Alarm block of five bytes in fixed order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lo_trig_r    <= 8'h00;
         lo_out_r     <= 8'h00;
         hi_trig_r    <= 8'h00;
         hi_out_r     <= 8'h00;
         alarm_ctrl_r <= 8'h00;
      end
      else
      begin
         if (wsel_lo_t) lo_trig_r <= wdata_r[7:0];
         if (wsel_lo_o) lo_out_r <= wdata_r[7:0];
         if (wsel_hi_t) hi_trig_r <= wdata_r[7:0];
         if (wsel_hi_o) hi_out_r <= wdata_r[7:0];
         if (wsel_actl) alarm_ctrl_r <= wdata_r[7:0];
      end
   end

   // Steering control, mode byte and fallback value
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         steer_ctrl_r <= 8'h00;
         mode_r       <= 8'h00;
         fallback_r   <= 10'h000;
         irq_mask_r   <= '0;
      end
      else
      begin
         if (wsel_sctl) steer_ctrl_r <= wdata_r[7:0];
         if (wsel_mode) mode_r <= wdata_r[7:0];
         if (wsel_fb && wstrb_r[0]) fallback_r[7:0] <= wdata_r[7:0];
         if (wsel_fb && wstrb_r[1]) fallback_r[9:8] <= wdata_r[9:8];
         if (wsel_imask) irq_mask_r <= wdata_r[alsc_pkg::IRQ_W-1:0];
      end
   end

   // Three transition levels, one register each
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_lvl
         wire [7:0] off = alsc_pkg::OFF_STEER_LVL0 + 8'(4 * gi);
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               lvl_r[gi] <= 8'h00;
            else if (wr_byte0 && awaddr_r == off)
               lvl_r[gi] <= wdata_r[7:0];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Mode selection: steering wins over alarm, so they never run together
   wire steer_en = mode_r[alsc_pkg::MODE_STEER_BIT];
   wire alarm_en = mode_r[alsc_pkg::MODE_ALARM_BIT] & ~steer_en;
   alsc_pkg::alsc_mode_e mode_now;
   assign mode_now = steer_en ? alsc_pkg::ST_STEER :
                     alarm_en ? alsc_pkg::ST_ALARM : alsc_pkg::ST_NORMAL;

   // Shared selector fed by whichever control byte owns the comparator
   wire [3:0] sel_code = steer_en
                         ? steer_ctrl_r[alsc_pkg::SEL_MSB:alsc_pkg::SEL_LSB]
                         : alarm_ctrl_r[alsc_pkg::SEL_MSB:alsc_pkg::SEL_LSB];
   logic [9:0] sel_sample;
   logic       sel_ok;
   always_comb
   begin
      sel_ok = 1'b1;
      unique case (sel_code)
         alsc_pkg::SEL_TEMP_AMP:   sel_sample = samples.temperature_amp_out;
         alsc_pkg::SEL_INSTR_AMP:  sel_sample = samples.instr_amp_out;
         alsc_pkg::SEL_GAIN_STAGE: sel_sample = samples.gain_stage_out;
         alsc_pkg::SEL_VOLT_MODE:  sel_sample = samples.voltage_mode_out;
         alsc_pkg::SEL_GP_PIN_A:   sel_sample = samples.gp_pin_a;
         alsc_pkg::SEL_GP_PIN_B:   sel_sample = samples.gp_pin_b;
         default:
         begin
            sel_sample = 10'h000;
            sel_ok     = 1'b0;
         end
      endcase
   end

   // Compare the top eight bits only
   wire [7:0] sel_top  = sel_sample[9:2];
   wire       below_lo = sel_ok && sel_top < lo_trig_r;
   wire       above_hi = sel_ok && sel_top > hi_trig_r;
   wire [1:0] level    = {1'b0, sel_top >= lvl_r[0]} + {1'b0, sel_top >= lvl_r[1]}
                         + {1'b0, sel_top >= lvl_r[2] && sel_top >= lvl_r[1]};
   wire       cksum_bad = mode_r[alsc_pkg::MODE_CKSUM_BIT] & cksum_fail;

   // Next output value: checksum fallback first, then alarm clamps
   logic [9:0] out_nxt;
   logic       dig_nxt;
   always_comb
   begin
      out_nxt = conditioned_out;
      dig_nxt = mode_r[alsc_pkg::MODE_DIG_BIT];
      if (cksum_bad)
      begin
         out_nxt = fallback_r;
         dig_nxt = 1'b1;
      end
      else if (mode_now == alsc_pkg::ST_ALARM && below_lo)
      begin
         out_nxt = {lo_out_r, 2'b00};
         dig_nxt = 1'b1;
      end
      else if (mode_now == alsc_pkg::ST_ALARM && above_hi)
      begin
         out_nxt = {hi_out_r, 2'b00};
         dig_nxt = 1'b1;
      end
   end

   // Outputs refresh on each new sample, pin levels only while steering; pin enables follow steering every cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         drive_out           <= 10'h000;
         digital_output_mode <= 1'b0;
         gp_pins_out         <= 2'b00;
         gp_pins_oe_n        <= 2'b11;
      end
      else
      begin
         gp_pins_oe_n <= steer_en ? 2'b00 : 2'b11;
         if (sample_valid)
         begin
            drive_out           <= out_nxt;
            digital_output_mode <= dig_nxt;
            if (steer_en)
               gp_pins_out <= level;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: events set, write-one clears, set wins
   wire [alsc_pkg::IRQ_W-1:0] irq_ev =
      {sample_valid & cksum_bad,
       sample_valid & steer_en & (level != gp_pins_out),
       sample_valid & alarm_en & above_hi,
       sample_valid & alarm_en & below_lo};
   wire [alsc_pkg::IRQ_W-1:0] irq_clr = wsel_istat ? wdata_r[alsc_pkg::IRQ_W-1:0] : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_r <= '0;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
         irq <= |(((irq_stat_r & ~irq_clr) | irq_ev) & irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         alsc_pkg::OFF_ALARM_LO_TRIG: rd_mux[7:0] = lo_trig_r;
         alsc_pkg::OFF_ALARM_LO_OUT:  rd_mux[7:0] = lo_out_r;
         alsc_pkg::OFF_ALARM_HI_TRIG: rd_mux[7:0] = hi_trig_r;
         alsc_pkg::OFF_ALARM_HI_OUT:  rd_mux[7:0] = hi_out_r;
         alsc_pkg::OFF_ALARM_CTRL:    rd_mux[7:0] = alarm_ctrl_r;
         alsc_pkg::OFF_STEER_CTRL:    rd_mux[7:0] = steer_ctrl_r;
         alsc_pkg::OFF_STEER_LVL0:    rd_mux[7:0] = lvl_r[0];
         alsc_pkg::OFF_STEER_LVL1:    rd_mux[7:0] = lvl_r[1];
         alsc_pkg::OFF_STEER_LVL2:    rd_mux[7:0] = lvl_r[2];
         alsc_pkg::OFF_MODE:          rd_mux[7:0] = mode_r;
         alsc_pkg::OFF_FALLBACK:      rd_mux[9:0] = fallback_r;
         alsc_pkg::OFF_STATUS:        rd_mux[15:0] = {gp_pins_out, digital_output_mode,
                                                      sel_ok, 2'b00, drive_out};
         alsc_pkg::OFF_IRQ_STAT:      rd_mux[alsc_pkg::IRQ_W-1:0] = irq_stat_r;
         alsc_pkg::OFF_IRQ_MASK:      rd_mux[alsc_pkg::IRQ_W-1:0] = irq_mask_r;
         default:                     rd_mux = 32'h0000_0000;
      endcase
   end
   wire rd_hit = (s_axi_araddr <= alsc_pkg::OFF_IRQ_MASK) && (s_axi_araddr[1:0] == 2'h0);

   // One read at a time: arready pulses, data follows next cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= alsc_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_take)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? alsc_pkg::RESP_OKAY : alsc_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_low_hit;
      sample_valid && !cksum_bad && alarm_en && below_lo;
   endsequence

   a_alarm_low_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
      s_low_hit |=> drive_out == {$past(lo_out_r), 2'b00} && digital_output_mode)
      else $error("low alarm value not driven");
   a_alarm_high_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_valid && !cksum_bad && alarm_en && above_hi && !below_lo
      |=> drive_out == {$past(hi_out_r), 2'b00})
      else $error("high alarm value not driven");
   a_steer_blocks_alarm: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_valid && steer_en && !cksum_bad |=> drive_out == $past(conditioned_out))
      else $error("alarm active during steering");
   a_cksum_fallback: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_valid && cksum_bad |=> drive_out == $past(fallback_r))
      else $error("fallback value not driven");
   a_pins_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 gp_pins_oe_n == ($past(steer_en) ? 2'b00 : 2'b11))
      else $error("pin enable mismatch");
   a_steer_level: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_valid && steer_en |=> gp_pins_out == $past(level))
      else $error("steering level not shown");
   a_hold_no_sample: assert property (@(posedge aclk) disable iff (!aresetn)
      !sample_valid |=> $stable(drive_out))
      else $error("output changed without sample");
   a_pass_through: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_valid && !cksum_bad && !alarm_en |=> drive_out == $past(conditioned_out))
      else $error("conditioned value not passed");

endmodule

// ### verification/alsc_chain_model.sv
// Behavioural model of the analog chain that feeds the comparator
`timescale 1ns/1ps

module alsc_chain_model
(
   // Clock
   input  wire logic                    aclk,
   // Samples towards the comparator
   output      alsc_pkg::alsc_samples_s samples,
   output      logic                    sample_valid,
   output      logic [9:0]              conditioned_out,
   output      logic                    cksum_fail
);

   // Quiet chain at time zero
   initial
   begin
      samples = '0;
      sample_valid = 1'b0;
      conditioned_out = 10'h155;
      cksum_fail = 1'b0;
   end

   // One new sample; other channels carry the inverse so a wrong pick shows
   task automatic send(input int k, input logic [9:0] v, input logic f);
      logic [59:0] s;
      s = {6{~v}};
      s[59-10*k -: 10] = v;
      @(posedge aclk);
      samples <= alsc_pkg::alsc_samples_s'(s);
      cksum_fail <= f;
      sample_valid <= 1'b1;
      @(posedge aclk);
      sample_valid <= 1'b0;
      repeat (2) @(posedge aclk);
      #1;
   endtask

endmodule

// ### verification/alsc_bench.sv
// Self-checking bench for the alarm and level steering comparator
`timescale 1ns/1ps

module alsc_bench;

   localparam logic [1:0]  OK = alsc_pkg::RESP_OKAY;
   localparam logic [1:0]  ER = alsc_pkg::RESP_SLVERR;
   localparam logic [31:0] M_AL = 32'h1 << alsc_pkg::MODE_ALARM_BIT;
   localparam logic [31:0] M_ST = 32'h1 << alsc_pkg::MODE_STEER_BIT;
   localparam logic [31:0] M_CK = 32'h1 << alsc_pkg::MODE_CKSUM_BIT;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, dmode, irq, svalid, cfail;
   logic [1:0]  bresp, rresp, pins, pins_oe_n;
   logic [31:0] rdata;
   logic [9:0]  drive, cond;
   alsc_pkg::alsc_samples_s smp;
   int          err_total = 0;
   int          compares = 0;
   int          cycles = 0;
   logic [3:0]  code [6] = '{4'b0010, 4'b0110, 4'b0000, 4'b0011, 4'b0100, 4'b0101};
   logic [7:0]  lv [4] = '{8'h20, 8'h60, 8'ha0, 8'he0};

   ////////////////////////////////////////////////////////////
   // Free-running 125 MHz clock
   always #4 aclk = ~aclk;

   alsc_top uut
   (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .samples(smp), .sample_valid(svalid), .conditioned_out(cond), .cksum_fail(cfail),
      .drive_out(drive), .digital_output_mode(dmode), .gp_pins_out(pins),
      .gp_pins_oe_n(pins_oe_n), .irq(irq)
   );

   alsc_chain_model chain
   (
      .aclk(aclk), .samples(smp), .sample_valid(svalid), .conditioned_out(cond),
      .cksum_fail(cfail)
   );

   ////////////////////////////////////////////////////////////
   // Compare and verdict
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic final_report();
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Hang guard; the whole run needs a few hundred cycles
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         err_total++;
         final_report();
      end
   end

   // Write; address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(e));
   endtask

   // Read and compare data and response
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", rdata, e);
      chk("rresp", 32'(rresp), 32'(er));
   endtask

   // Output stage; pin levels only matter while the pins are driven
   task automatic outs(input logic [9:0] d, input logic m, input logic [1:0] p,
                       input logic [1:0] oe);
      chk("drive_out", 32'(drive), 32'(d));
      chk("digital_output_mode", 32'(dmode), 32'(m));
      chk("gp_pins_oe_n", 32'(pins_oe_n), 32'(oe));
      if (oe == 2'b00)
         chk("gp_pins_out", 32'(pins), 32'(p));
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      outs(10'h0, 1'b0, 2'b00, 2'b11);
      chk("irq", 32'(irq), 32'h0);
      wr(8'h3c, 32'h1, ER);
      wr(8'h02, 32'h1, ER);
      rchk(8'h38, 32'h0, ER);
      rchk(alsc_pkg::OFF_IRQ_MASK, 32'h0, OK);
      // Alarm setup; only the low byte lane is kept
      wr(alsc_pkg::OFF_ALARM_LO_TRIG, 32'hffff_ff40, OK);
      rchk(alsc_pkg::OFF_ALARM_LO_TRIG, 32'h40, OK);
      wr(alsc_pkg::OFF_ALARM_LO_OUT, 32'h11, OK);
      wr(alsc_pkg::OFF_ALARM_HI_TRIG, 32'hc0, OK);
      wr(alsc_pkg::OFF_ALARM_HI_OUT, 32'hee, OK);
      wr(alsc_pkg::OFF_MODE, M_AL, OK);
      // Every selector code, both triggers and their exact boundaries
      for (int i = 0; i < 6; i++)
      begin
         wr(alsc_pkg::OFF_ALARM_CTRL, 32'({code[i], 4'h0}), OK);
         chain.send(i, {8'h3f, 2'b11}, 1'b0);
         outs({8'h11, 2'b00}, 1'b1, 2'b00, 2'b11);
         chain.send(i, {8'h40, 2'b00}, 1'b0);
         outs(10'h155, 1'b0, 2'b00, 2'b11);
         chain.send(i, {8'hc1, 2'b00}, 1'b0);
         outs({8'hee, 2'b00}, 1'b1, 2'b00, 2'b11);
         chain.send(i, {8'hc0, 2'b11}, 1'b0);
         outs(10'h155, 1'b0, 2'b00, 2'b11);
      end
      // Sticky status, mask and write-one-to-clear
      rchk(alsc_pkg::OFF_IRQ_STAT, 32'h3, OK);
      chk("irq", 32'(irq), 32'h0);
      wr(alsc_pkg::OFF_IRQ_MASK, 32'hf, OK);
      rchk(alsc_pkg::OFF_IRQ_MASK, 32'hf, OK);
      chk("irq", 32'(irq), 32'h1);
      wr(alsc_pkg::OFF_IRQ_MASK, 32'h0, OK);
      rchk(alsc_pkg::OFF_IRQ_MASK, 32'h0, OK);
      chk("irq", 32'(irq), 32'h0);
      wr(alsc_pkg::OFF_IRQ_MASK, 32'hf, OK);
      wr(alsc_pkg::OFF_IRQ_STAT, 32'h3, OK);
      rchk(alsc_pkg::OFF_IRQ_STAT, 32'h0, OK);
      chk("irq", 32'(irq), 32'h0);
      // Steering on gain stage while the alarm selector points elsewhere
      wr(alsc_pkg::OFF_STEER_LVL0, 32'h40, OK);
      wr(alsc_pkg::OFF_STEER_LVL1, 32'h80, OK);
      wr(alsc_pkg::OFF_STEER_LVL2, 32'hc0, OK);
      wr(alsc_pkg::OFF_ALARM_CTRL, 32'h20, OK);
      wr(alsc_pkg::OFF_STEER_CTRL, 32'h00, OK);
      wr(alsc_pkg::OFF_MODE, M_AL | M_ST, OK);
      for (int i = 0; i < 4; i++)
      begin
         chain.send(2, {lv[i], 2'b00}, 1'b0);
         outs(10'h155, 1'b0, 2'(i), 2'b00);
      end
      rchk(alsc_pkg::OFF_IRQ_STAT, 32'h4, OK);
      wr(alsc_pkg::OFF_IRQ_STAT, 32'h4, OK);
      wr(alsc_pkg::OFF_MODE, 32'h0, OK);
      chain.send(2, {8'h20, 2'b00}, 1'b0);
      outs(10'h155, 1'b0, 2'b00, 2'b11);
      // Checksum fallback beats the alarm, only while the test is on
      wr(alsc_pkg::OFF_FALLBACK, 32'h2a5, OK);
      wr(alsc_pkg::OFF_ALARM_CTRL, 32'h00, OK);
      wr(alsc_pkg::OFF_MODE, M_CK | M_AL, OK);
      chain.send(2, {8'h10, 2'b00}, 1'b1);
      outs(10'h2a5, 1'b1, 2'b00, 2'b11);
      chain.send(2, {8'h10, 2'b00}, 1'b0);
      outs({8'h11, 2'b00}, 1'b1, 2'b00, 2'b11);
      wr(alsc_pkg::OFF_MODE, M_AL, OK);
      chain.send(2, {8'h10, 2'b00}, 1'b1);
      outs({8'h11, 2'b00}, 1'b1, 2'b00, 2'b11);
      rchk(alsc_pkg::OFF_IRQ_STAT, 32'h9, OK);
      // Alarm unused: all alarm bytes zero, digital mode with both outputs on
      for (int i = 0; i < 5; i++)
         wr(8'(4 * i), 32'h0, OK);
      wr(alsc_pkg::OFF_MODE, 32'h45, OK);
      chain.send(2, {8'h10, 2'b00}, 1'b0);
      outs(10'h155, 1'b1, 2'b00, 2'b11);
      // An unknown selector code selects nothing; status shows it
      wr(alsc_pkg::OFF_ALARM_CTRL, 32'hf0, OK);
      rchk(alsc_pkg::OFF_STATUS, 32'he155, OK);
      final_report();
   end

endmodule
